// >>> design/trswd_regs.svh
// constants of the transponder read sequencer and gap write decoder
`ifndef TRSWD_REGS_SVH
`define TRSWD_REGS_SVH
`define TRSWD_LOAD_CLKS 9'h100
`define TRSWD_ZERO_MIN 7'h10
`define TRSWD_ZERO_MAX 7'h20
`define TRSWD_ONE_MIN 7'h30
`define TRSWD_ONE_MAX 7'h40
`define TRSWD_GAP_TIMEOUT 7'h40
`define TRSWD_BITS_STOP 7'h02
`define TRSWD_BITS_DIRECT 7'h06
`define TRSWD_BITS_WAKE 7'h22
`define TRSWD_BITS_STD 7'h26
`define TRSWD_BITS_PWD 7'h46
`define TRSWD_BITS_SAT 7'h7f
`define TRSWD_OP_WRITE 2'h2
`define TRSWD_OP_STOP 2'h3
`define TRSWD_FIRST_BLOCK 3'h1
`define TRSWD_CFG_BLOCK 3'h0
`define TRSWD_CFG_RST 16'h0000
`endif

// >>> design/trswd_pkg.sv
// types of the transponder read sequencer and gap write decoder
package trswd_pkg;
   typedef enum logic [5:0] {
      ST_LOAD = 6'h01,
      ST_BTERM = 6'h02,
      ST_BLOCK = 6'h04,
      ST_STERM = 6'h08,
      ST_WRITE = 6'h10,
      ST_PROG = 6'h20
   } trswd_state_t;
   // mode register image of configuration block 0
   typedef struct packed {
      logic [2:0] last_read_block;
      logic seq_term_enable;
      logic block_term_enable;
      logic password_mode;
      logic wake_gate_mode;
      logic stop_ignore;
      logic [1:0] first_modulator_select;
      logic [2:0] second_modulator_select;
      logic [2:0] bit_rate_select;
   } trswd_cfg_t;
   typedef struct packed {
      logic is_term;
      logic [2:0] block;
   } trswd_item_t;
   typedef struct packed {
      logic [2:0] addr;
      logic lock;
      logic [31:0] data;
   } trswd_prog_t;
endpackage

// >>> design/trswd_core.sv
// read sequencer, mode gating and gap-interval write decoder of the transponder
`include "trswd_regs.svh"

// Contract
// [R1] cycle blocks one to last, then wrap
// [R2] last block zero repeats configuration block
// [R3] block terminator before blocks, sequence after last
// [R4] sequence terminator is two block terminators
// [R5] terminators enabled by separate mode bits; after programming, either bit enables the block terminator
// [R6] no sequence terminator when last is zero
// [R7] reader avoids terminators with biphase coding
// [R8] opcode, lock, address reads one block
// [R9] direct access only without password mode
// [R10] modulator and bit rate from block zero
// [R11] wake gate keeps modulation off until wake
// [R12] reader wakes with opcode and password
// [R13] woken tag stays active until stop
// [R14] password plus wake gate needs password everywhere
// [R15] password mode modulates, programs with password
// [R16] wake gate alone allows blind programming
// [R17] stop opcode silences unless stop ignored
// [R18] write frame: opcode, lock, data, address
// [R19] program only with exact bit count
// [R20] count field clocks between gaps
// [R21] zero is 16..32, one 48..64
// [R22] bad interval abandons write, resumes read
// [R23] reader encodes bits in gap spacing
// [R24] load block zero silent 256 clocks
// [R25] read starts block one, mode refreshed
// [R26] silence over 64 clocks ends write
// [R27] write errors restart read at block one
// [R28] all counting on recovered field clock
module trswd_core
   import trswd_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic field_clk,
   input wire logic field_on,
   input wire trswd_cfg_t block0_cfg,
   input wire logic [31:0] pwd_word,
   input wire logic tx_done,
   input wire logic prog_done,
   output trswd_cfg_t mode_cfg,
   output logic mod_enable,
   output logic damp_force,
   output logic tx_valid,
   output trswd_item_t tx_item,
   output logic prog_req,
   output trswd_prog_t prog_word
);

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   logic [2:0] fclk_sync_r;
   logic [2:0] fon_sync_r;
   logic fclk_edge;
   logic gap_start;

   // stage 0 feeds only stage 1; stage 2 is the delayed copy for edges
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         fclk_sync_r <= 3'h0;
         fon_sync_r <= 3'h0;
      end
      else
      begin
         fclk_sync_r <= {fclk_sync_r[1:0], field_clk};
         fon_sync_r <= {fon_sync_r[1:0], field_on};
      end
   end

   // [R28] recovered field clock
   assign fclk_edge = fclk_sync_r[1] & ~fclk_sync_r[2];
   // [R23] gap is field loss
   assign gap_start = fon_sync_r[2] & ~fon_sync_r[1];

   // ----------------------------------------------------------------
   // sequencer and decoder state
   // ----------------------------------------------------------------
   trswd_state_t state_r, state_nxt;
   logic [8:0] load_cnt_r, load_cnt_nxt;
   logic [6:0] gap_cnt_r, gap_cnt_nxt;
   logic [6:0] bit_cnt_r, bit_cnt_nxt;
   logic [69:0] rx_sr_r, rx_sr_nxt;
   logic [2:0] cur_blk_r, cur_blk_nxt;
   logic sterm_cnt_r, sterm_cnt_nxt;
   logic single_r, single_nxt;
   logic awake_r, awake_nxt;
   logic stopped_r, stopped_nxt;
   trswd_cfg_t cfg_r, cfg_nxt;
   logic mod_enable_r, mod_enable_nxt;
   logic damp_force_r, damp_force_nxt;
   logic tx_valid_r, tx_valid_nxt;
   trswd_item_t tx_item_r, tx_item_nxt;
   logic prog_req_r, prog_req_nxt;
   trswd_prog_t prog_word_r, prog_word_nxt;
   logic is_zero;
   logic is_one;
   logic tx_state;

   // first item of a block: terminator or block itself
   function automatic trswd_state_t first_item(input logic term);
      first_item = term ? ST_BTERM : ST_BLOCK;
   endfunction

   always_comb
   begin
      state_nxt = state_r;
      load_cnt_nxt = load_cnt_r;
      gap_cnt_nxt = gap_cnt_r;
      bit_cnt_nxt = bit_cnt_r;
      rx_sr_nxt = rx_sr_r;
      cur_blk_nxt = cur_blk_r;
      sterm_cnt_nxt = sterm_cnt_r;
      single_nxt = single_r;
      awake_nxt = awake_r;
      stopped_nxt = stopped_r;
      cfg_nxt = cfg_r;
      prog_req_nxt = 1'h0;
      prog_word_nxt = prog_word_r;
      // [R21] interval windows
      is_zero = (gap_cnt_r >= `TRSWD_ZERO_MIN) && (gap_cnt_r <= `TRSWD_ZERO_MAX);
      is_one = (gap_cnt_r >= `TRSWD_ONE_MIN) && (gap_cnt_r <= `TRSWD_ONE_MAX);
      tx_state = (state_r == ST_BTERM) || (state_r == ST_BLOCK) || (state_r == ST_STERM);
      case (state_r)
         ST_LOAD:
         begin
            // [R24] silent load, any gap restarts it
            if (gap_start)
               load_cnt_nxt = 9'h000;
            else if (fclk_edge)
            begin
               if (load_cnt_r == `TRSWD_LOAD_CLKS - 9'h001)
               begin
                  // [R10] mode latched from block zero
                  cfg_nxt = block0_cfg;
                  // [R2] block zero loop when last is zero
                  cur_blk_nxt = (block0_cfg.last_read_block == `TRSWD_CFG_BLOCK) ?
                     `TRSWD_CFG_BLOCK : `TRSWD_FIRST_BLOCK;
                  state_nxt = first_item(block0_cfg.block_term_enable);
               end
               else
                  load_cnt_nxt = load_cnt_r + 9'h001;
            end
         end
         ST_BTERM:
         begin
            if (tx_done)
               state_nxt = ST_BLOCK;
         end
         ST_BLOCK:
         begin
            if (tx_done)
            begin
               // [R25] mode register refreshed every block
               cfg_nxt = block0_cfg;
               // [R3] block terminator per block, enabled by its bit
               state_nxt = first_item(cfg_r.block_term_enable);
               if (single_r)
                  cur_blk_nxt = cur_blk_r;
               // [R6] no sequence terminator in block zero loop
               else if (cfg_r.last_read_block == `TRSWD_CFG_BLOCK)
                  cur_blk_nxt = `TRSWD_CFG_BLOCK;
               // [R1] wrap after the last block
               else if (cur_blk_r == cfg_r.last_read_block)
               begin
                  cur_blk_nxt = `TRSWD_FIRST_BLOCK;
                  // [R5] sequence terminator has its own bit
                  if (cfg_r.seq_term_enable)
                  begin
                     state_nxt = ST_STERM;
                     sterm_cnt_nxt = 1'h0;
                  end
               end
               else
                  cur_blk_nxt = cur_blk_r + 3'h1;
            end
         end
         ST_STERM:
         begin
            // [R4] two terminators back to back
            if (tx_done)
            begin
               if (sterm_cnt_r)
                  state_nxt = first_item(cfg_r.block_term_enable);
               else
                  sterm_cnt_nxt = 1'h1;
            end
         end
         ST_WRITE:
         begin
            if (gap_start)
            begin
               // [R20] each gap closes an interval
               gap_cnt_nxt = 7'h00;
               if (is_zero || is_one)
               begin
                  rx_sr_nxt = {rx_sr_r[68:0], is_one};
                  if (bit_cnt_r != `TRSWD_BITS_SAT)
                     bit_cnt_nxt = bit_cnt_r + 7'h01;
               end
               else
               begin
                  // [R22] bad interval leaves write at once
                  cur_blk_nxt = `TRSWD_FIRST_BLOCK;
                  state_nxt = first_item(cfg_r.block_term_enable);
               end
            end
            else if (fclk_edge)
            begin
               if (gap_cnt_r != `TRSWD_GAP_TIMEOUT)
                  gap_cnt_nxt = gap_cnt_r + 7'h01;
               else
               begin
                  // [R26] silence ends the frame; [R27] default restart at block one
                  cur_blk_nxt = `TRSWD_FIRST_BLOCK;
                  state_nxt = first_item(cfg_r.block_term_enable);
                  // [R19] outcome chosen by exact bit count
                  case (bit_cnt_r)
                     `TRSWD_BITS_STOP:
                     begin
                        // [R17] stop unless ignored
                        if ((rx_sr_r[1:0] == `TRSWD_OP_STOP) && !cfg_r.stop_ignore)
                           stopped_nxt = 1'h1;
                     end
                     `TRSWD_BITS_DIRECT:
                     begin
                        // [R8] [R9] direct access, password mode off only
                        if ((rx_sr_r[5:4] == `TRSWD_OP_WRITE) && !cfg_r.password_mode)
                        begin
                           single_nxt = 1'h1;
                           cur_blk_nxt = rx_sr_r[2:0];
                        end
                     end
                     `TRSWD_BITS_WAKE:
                     begin
                        // [R12] [R13] wake on opcode and matching password
                        if ((rx_sr_r[33:32] == `TRSWD_OP_WRITE) && cfg_r.wake_gate_mode &&
                            (rx_sr_r[31:0] == pwd_word))
                           awake_nxt = 1'h1;
                     end
                     `TRSWD_BITS_STD:
                     begin
                        // [R18] [R16] lock, data, address without password
                        if ((rx_sr_r[37:36] == `TRSWD_OP_WRITE) && !cfg_r.password_mode)
                        begin
                           prog_req_nxt = 1'h1;
                           prog_word_nxt = {rx_sr_r[2:0], rx_sr_r[35], rx_sr_r[34:3]};
                           cur_blk_nxt = rx_sr_r[2:0];
                           state_nxt = ST_PROG;
                        end
                     end
                     `TRSWD_BITS_PWD:
                     begin
                        // [R14] [R15] program only with matching password
                        if ((rx_sr_r[69:68] == `TRSWD_OP_WRITE) && cfg_r.password_mode &&
                            (rx_sr_r[67:36] == pwd_word))
                        begin
                           prog_req_nxt = 1'h1;
                           prog_word_nxt = {rx_sr_r[2:0], rx_sr_r[35], rx_sr_r[34:3]};
                           cur_blk_nxt = rx_sr_r[2:0];
                           state_nxt = ST_PROG;
                        end
                     end
                     default:
                        cur_blk_nxt = `TRSWD_FIRST_BLOCK;
                  endcase
               end
            end
         end
         ST_PROG:
         begin
            // resume with the programmed block, terminator if either is on
            if (prog_done)
               state_nxt = first_item(cfg_r.block_term_enable | cfg_r.seq_term_enable);
         end
         default:
            state_nxt = ST_LOAD;
      endcase
      // start gap opens write mode from any read state
      if (gap_start && tx_state)
      begin
         state_nxt = ST_WRITE;
         gap_cnt_nxt = 7'h00;
         bit_cnt_nxt = 7'h00;
         rx_sr_nxt = 70'h0;
         single_nxt = 1'h0;
      end
      // [R11] [R14] [R16] gating hides read-back while not woken
      mod_enable_nxt = ((state_nxt == ST_BTERM) || (state_nxt == ST_BLOCK) ||
                        (state_nxt == ST_STERM)) && !stopped_nxt &&
                       (!cfg_nxt.wake_gate_mode || awake_nxt);
      // damping stays on through write to ease gap detection
      damp_force_nxt = (state_nxt == ST_WRITE);
      // valid drops for one cycle after each done so items never merge
      tx_valid_nxt = mod_enable_nxt && !tx_done;
      tx_item_nxt = {state_nxt != ST_BLOCK, cur_blk_nxt};
   end

   // registers; sys_rst is the reset, which clears stop and wake
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         state_r <= ST_LOAD;
         load_cnt_r <= 9'h000;
         gap_cnt_r <= 7'h00;
         bit_cnt_r <= 7'h00;
         rx_sr_r <= 70'h0;
         cur_blk_r <= `TRSWD_FIRST_BLOCK;
         sterm_cnt_r <= 1'h0;
         single_r <= 1'h0;
         awake_r <= 1'h0;
         stopped_r <= 1'h0;
         cfg_r <= `TRSWD_CFG_RST;
         mod_enable_r <= 1'h0;
         damp_force_r <= 1'h0;
         tx_valid_r <= 1'h0;
         tx_item_r <= 4'h0;
         prog_req_r <= 1'h0;
         prog_word_r <= 36'h0;
      end
      else
      begin
         state_r <= state_nxt;
         load_cnt_r <= load_cnt_nxt;
         gap_cnt_r <= gap_cnt_nxt;
         bit_cnt_r <= bit_cnt_nxt;
         rx_sr_r <= rx_sr_nxt;
         cur_blk_r <= cur_blk_nxt;
         sterm_cnt_r <= sterm_cnt_nxt;
         single_r <= single_nxt;
         awake_r <= awake_nxt;
         stopped_r <= stopped_nxt;
         cfg_r <= cfg_nxt;
         mod_enable_r <= mod_enable_nxt;
         damp_force_r <= damp_force_nxt;
         tx_valid_r <= tx_valid_nxt;
         tx_item_r <= tx_item_nxt;
         prog_req_r <= prog_req_nxt;
         prog_word_r <= prog_word_nxt;
      end
   end

   assign mode_cfg = cfg_r;
   assign mod_enable = mod_enable_r;
   assign damp_force = damp_force_r;
   assign tx_valid = tx_valid_r;
   assign tx_item = tx_item_r;
   assign prog_req = prog_req_r;
   assign prog_word = prog_word_r;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   sequence s_term_done;
      (state_r == ST_STERM) && tx_done && !gap_start;
   endsequence
   sequence s_wrap_point;
      (state_r == ST_BLOCK) && tx_done && !gap_start && !single_r &&
      (cfg_r.last_read_block != 3'h0) && (cur_blk_r == cfg_r.last_read_block);
   endsequence

   chk_wrap_block_one: assert property ( // [R1]
      s_wrap_point |=> (cur_blk_r == 3'h1) && (state_r == ($past(cfg_r.seq_term_enable) ?
         ST_STERM : $past(first_item(cfg_r.block_term_enable)))))
      else $error("read cycle did not wrap to block one");
   chk_sterm_pair: assert property ( // [R4]
      s_term_done ##0 !sterm_cnt_r |=> (state_r == ST_STERM) && sterm_cnt_r)
      else $error("sequence terminator not doubled");
   chk_no_sterm_zero: assert property ( // [R6]
      (cfg_r.last_read_block == 3'h0) |-> (state_r != ST_STERM))
      else $error("sequence terminator in block zero loop");
   chk_load_silent: assert property ( // [R24]
      (state_r == ST_LOAD) |-> !mod_enable_r && !tx_valid_r && !damp_force_r)
      else $error("activity during configuration load");
   chk_stop_silent: assert property ( // [R17]
      stopped_r |-> !mod_enable_r && !tx_valid_r)
      else $error("modulating after stop");
   chk_wake_gate: assert property ( // [R11]
      (cfg_r.wake_gate_mode && !awake_r) |-> !mod_enable_r)
      else $error("modulating before wake-up");
   chk_pwd_direct: assert property ( // [R9]
      $rose(single_r) |-> !$past(cfg_r.password_mode) && $past(bit_cnt_r) == 7'h06)
      else $error("direct access taken in password mode");
   chk_prog_count: assert property ( // [R19]
      prog_req_r |-> ($past(bit_cnt_r) == 7'h26) || ($past(bit_cnt_r) == 7'h46))
      else $error("programming with wrong bit count");
   chk_zero_bit: assert property ( // [R21]
      (state_r == ST_WRITE) && gap_start && (gap_cnt_r >= 7'h10) && (gap_cnt_r <= 7'h20)
      |=> !rx_sr_r[0] && (state_r == ST_WRITE))
      else $error("zero interval misdecoded");
   chk_one_bit: assert property ( // [R21]
      (state_r == ST_WRITE) && gap_start && (gap_cnt_r >= 7'h30) && (gap_cnt_r <= 7'h40)
      |=> rx_sr_r[0] && (state_r == ST_WRITE))
      else $error("one interval misdecoded");
   chk_bad_interval: assert property ( // [R22]
      (state_r == ST_WRITE) && gap_start && (gap_cnt_r > 7'h20) && (gap_cnt_r < 7'h30)
      |=> (state_r != ST_WRITE) && (cur_blk_r == 3'h1) && !prog_req_r)
      else $error("bad interval did not end write");
   chk_start_gap: assert property ( // [R20]
      gap_start && ((state_r == ST_BLOCK) || (state_r == ST_BTERM))
      |=> (state_r == ST_WRITE) && damp_force_r && (gap_cnt_r == 7'h00) [*2])
      else $error("start gap did not open write mode");

endmodule // trswd_core

// >>> test/trswd_reader.sv
// reader model: free-running field clock and gap-coded write frames
module trswd_reader (
   output logic field_clk,
   output logic field_on
);
   timeunit 1ns;
   timeprecision 100ps;

   // ----------------------------------------
   // carrier and field
   // ----------------------------------------
   // carrier runs free; offset keeps its edges clear of the core clock edges
   initial
   begin
      field_clk = 1'b0;
      #3;
      forever #16 field_clk = ~field_clk;
   end

   // field stays present outside gaps
   initial field_on = 1'b1;

   // ----------------------------------------
   // write frames
   // ----------------------------------------
   // one short field interruption of two carrier periods
   task automatic gap();
      @(negedge field_clk);
      field_on = 1'b0;
      repeat (2) @(negedge field_clk);
      field_on = 1'b1;
   endtask

   // gap spacing, msb first
   // nominal spacings sit mid-window so sync jitter cannot push them out
   task automatic send(input logic [69:0] f, input int n, input bit bad);
      int i;
      gap();
      for (i = n - 1; i >= 0; i--)
      begin
         repeat ((bad && i == 0) ? 38 : (f[i] ? 54 : 22)) @(posedge field_clk);
         gap();
      end
      repeat (80) @(posedge field_clk); // outlast the frame timeout
   endtask
endmodule // trswd_reader

// >>> test/trswd_core_test.sv
// self-checking bench of the read sequencer and gap write decoder
module trswd_core_test
   import trswd_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic ref_clk;
   logic sys_rst;
   logic tx_done = 1'b0;
   logic prog_done = 1'b0;
   logic field_clk;
   logic field_on;
   logic [31:0] pwd_word;
   logic [31:0] data;
   trswd_cfg_t block0_cfg;
   trswd_cfg_t mode_cfg;
   trswd_item_t tx_item;
   trswd_prog_t prog_word;
   logic mod_enable, damp_force, tx_valid, prog_req;
   logic [3:0] seen[$];
   logic [3:0] exp_q[$];
   trswd_prog_t prog_q[$];
   bit en_ack;
   int ack_cnt, ack_dly, fail_count, checks, t;
   int lim[4] = '{3, 0, 2, 7};
   bit tb[4] = '{1, 0, 0, 0};
   bit ts[4] = '{1, 1, 0, 1};

   trswd_reader i_rdr (.field_clk(field_clk), .field_on(field_on));

   trswd_core i_dut (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .field_clk(field_clk), .field_on(field_on),
      .block0_cfg(block0_cfg), .pwd_word(pwd_word), .tx_done(tx_done),
      .prog_done(prog_done), .mode_cfg(mode_cfg), .mod_enable(mod_enable),
      .damp_force(damp_force), .tx_valid(tx_valid), .tx_item(tx_item),
      .prog_req(prog_req), .prog_word(prog_word));

   // ----------------------------------------
   // coder and programmer stand-ins
   // ----------------------------------------
   // random hold before each acknowledge, so items must stand
   always @(negedge ref_clk)
   begin
      tx_done <= 1'b0;
      prog_done <= (prog_req === 1'b1);
      if (prog_req === 1'b1)
         prog_q.push_back(prog_word);
      if (en_ack && tx_valid === 1'b1 && tx_done !== 1'b1)
      begin
         if (ack_cnt >= ack_dly)
         begin
            tx_done <= 1'b1;
            seen.push_back(tx_item.is_term ? 4'h8 : {1'b0, tx_item.block});
            ack_cnt <= 0;
            ack_dly <= $urandom_range(4, 1);
         end
         else
            ack_cnt <= ack_cnt + 1;
      end
   end

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
      checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // first modulator select stays zero: never biphase beside terminators
   // no biphase terminators
   function automatic trswd_cfg_t mk(input int last, input bit bt, input bit st,
                                     input bit pw, input bit wk, input bit si);
      trswd_cfg_t c;
      c = '0;
      c.last_read_block = 3'(last);
      c.block_term_enable = bt;
      c.seq_term_enable = st;
      c.password_mode = pw;
      c.wake_gate_mode = wk;
      c.stop_ignore = si;
      c.second_modulator_select = 3'($urandom);
      c.bit_rate_select = 3'($urandom);
      return c;
   endfunction

   // expected item stream; 8 marks one terminator pattern
   task automatic build(input int last, input bit bt, input bit st, input int start,
                        input bit rep, input int n);
      int b;
      b = start;
      exp_q.delete();
      while (exp_q.size() < n)
      begin
         if (bt)
            exp_q.push_back(4'h8);
         exp_q.push_back(4'(b));
         if (last != 0 && !rep)
         begin
            if (b == last && st)
            begin
               exp_q.push_back(4'h8);
               exp_q.push_back(4'h8);
            end
            b = (b == last) ? 1 : b + 1;
         end
      end
   endtask

   task automatic read_chk(input string what, input int n);
      int i;
      en_ack = 1'b1;
      for (i = 0; i < 3000 && seen.size() < n; i++)
         @(posedge ref_clk);
      if (seen.size() < n)
      begin
         fail_count++;
         $display("Error %s expected %0d items seen %0d", what, n, seen.size());
         close_out();
      end
      for (i = 0; i < n; i++)
         chk(what, exp_q[i], seen[i]);
   endtask

   task automatic restart(input trswd_cfg_t c);
      int i;
      bit early;
      early = 1'b0;
      @(negedge ref_clk);
      sys_rst = 1'b1;
      block0_cfg = c;
      repeat (2) @(negedge ref_clk);
      sys_rst = 1'b0;
      seen.delete();
      prog_q.delete();
      for (i = 0; i < 2000; i++)
      begin
         @(negedge ref_clk);
         early |= (mod_enable !== 1'b0 || tx_valid !== 1'b0);
      end
      chk("silent load", 1'b0, early);
      repeat (200) @(negedge ref_clk);
      chk("mode image", c, mode_cfg);
   endtask

   // acks held off while the reader writes; stale items dropped after
   task automatic wr(input logic [69:0] f, input int n, input bit bad);
      @(posedge ref_clk);
      en_ack = 1'b0;
      // damping is sampled well inside the shortest frame
      fork
         i_rdr.send(f, n, bad);
         begin
            repeat (300) @(negedge ref_clk);
            chk("write damping", 1'b1, damp_force);
         end
      join
      chk("damping off", 1'b0, damp_force);
      seen.delete();
   endtask

   // ----------------------------------------
   // clock and sequence
   // ----------------------------------------
   initial
   begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   initial
   begin
      sys_rst = 1'b1;
      block0_cfg = '0;
      pwd_word = 32'h0000_0a5c;
      en_ack = 1'b1;
      ack_cnt = 0;
      ack_dly = 1;
      void'($urandom(32'h6cc6d7e6));
      for (t = 0; t < 4; t++)
      begin
         restart(mk(lim[t], tb[t], ts[t], 0, 0, 0));
         build(lim[t], tb[t], ts[t], (lim[t] != 0) ? 1 : 0, 0, 12);
         read_chk("read order", 12);
      end
      $display("test read order done");
      restart(mk(7, 0, 0, 0, 0, 0));
      wr({2'b10, 1'b0, 3'h3}, 6, 0);
      build(7, 0, 0, 3, 1, 3);
      read_chk("direct access", 3);
      wr({2'b10, 1'b1}, 3, 1);
      build(7, 0, 0, 1, 0, 3);
      read_chk("gap error", 3);
      wr(3'b101, 3, 0);
      read_chk("bit count", 3);
      data = $urandom;
      wr({2'b10, 1'b1, data, 3'h5}, 38, 0);
      chk("program count", 36'd1, 36'(prog_q.size()));
      chk("program word", {3'h5, 1'b1, data}, prog_q[0]);
      build(7, 0, 0, 5, 0, 4);
      read_chk("after program", 4);
      wr(2'b11, 2, 0);
      chk("stop silence", 2'b00, {mod_enable, tx_valid});
      $display("test plain write done");
      restart(mk(7, 0, 0, 1, 0, 0));
      wr({2'b10, 1'b0, 3'h3}, 6, 0);
      build(7, 0, 0, 1, 0, 3);
      read_chk("direct refused", 3);
      wr({2'b10, pwd_word, 1'b0, 32'h0, 3'h2}, 70, 0);
      chk("password program", {3'h2, 1'b0, 32'h0}, prog_q[0]);
      restart(mk(7, 0, 0, 1, 1, 0));
      chk("password gated", 1'b0, mod_enable);
      wr({2'b10, pwd_word}, 34, 0);
      chk("password wake", 1'b1, mod_enable);
      $display("test password done");
      restart(mk(7, 0, 0, 0, 0, 1));
      wr(2'b11, 2, 0);
      build(7, 0, 0, 1, 0, 2);
      read_chk("stop ignored", 2);
      $display("test stop ignore done");
      restart(mk(7, 0, 0, 0, 1, 0));
      chk("gated", 1'b0, mod_enable);
      wr({2'b10, 1'b0, 32'h0, 3'h6}, 38, 0);
      chk("blind program", {3'h6, 1'b0, 32'h0}, prog_q[0]);
      chk("no read back", 1'b0, mod_enable);
      wr({2'b10, pwd_word}, 34, 0);
      chk("woken", 1'b1, mod_enable);
      wr(2'b11, 2, 0);
      chk("woken stop", 1'b0, mod_enable);
      $display("test wake gate done");
      close_out();
   end
endmodule // trswd_core_test
